// ### hdl/capacity_threshold_flags_consts.svh
/*
  constants for the low-charge warning block: reset values, field positions and widths.
  assumes inclusion by bare name from design files.
*/
`ifndef CAPACITY_THRESHOLD_FLAGS_CONSTS_SVH
`define CAPACITY_THRESHOLD_FLAGS_CONSTS_SVH
`define CAP_W            16
`define LEVEL_W          8
`define FLAG_W           16
`define FLAG_BIT_FINAL   1
`define FLAG_BIT_INITIAL 2
`define LEVEL_DISABLED   8'hff
`define CHARGE_RESET     16'h0000
`define FLAGS_RESET      16'h0000
`define SENSE_W          16
`define ACC_W            32
`define ACC_RESET        32'h0000_0000
`define ACC_FRAC         16
`endif

// ### hdl/capacity_threshold_flags_pkg.sv
/*
  types shared by the low-charge warning block.
  assumes the constants header is available on the include path.
*/
`include "capacity_threshold_flags_consts.svh"
package capacity_threshold_flags_pkg;
  typedef logic [`CAP_W-1:0]   charge_t;
  typedef logic [`LEVEL_W-1:0] level_t;
  typedef enum logic [2:0] {
    st_idle    = 3'h1,
    st_compare = 3'h2,
    st_publish = 3'h4
  } eval_state_e;
endpackage : capacity_threshold_flags_pkg

// ### hdl/charge_update_if.sv
/*
  carries each new remaining-charge value from the integrator to the flag logic.
  assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
`include "capacity_threshold_flags_consts.svh"
interface charge_update_if;
  logic                                   valid;
  capacity_threshold_flags_pkg::charge_t  value;
  modport source (output valid, output value);
  modport sink   (input valid, input value);
endinterface : charge_update_if

// ### hdl/charge_integrator.sv
/*
  integrates signed sense-resistor samples into a remaining-charge value.
  assumes sample_valid marks one sense sample per pulse, in charge units scaled by ACC_FRAC.
*/
`timescale 1ns/10ps
`include "capacity_threshold_flags_consts.svh"
module charge_integrator (
  input  wire logic                      clock,
  input  wire logic                      srst,
  input  wire logic signed [`SENSE_W-1:0] sense_sample,
  input  wire logic                      sample_valid,
  input  wire logic                      load_en,
  input  wire logic [`CAP_W-1:0]         load_value,
  charge_update_if.source                upd
);
  logic [`ACC_W-1:0] acc_q;
  logic [`ACC_W-1:0] acc_d;
  logic [`ACC_W+1:0] sum;

  always_comb begin
    // two spare top bits keep the full unsigned range and expose underflow
    sum   = {2'b00, acc_q} + (`ACC_W+2)'(sense_sample);
    acc_d = acc_q;
    if (load_en) begin
      acc_d = {load_value, `ACC_FRAC'h0};
    end else if (sample_valid) begin
      // charge adds, discharge subtracts; floor at zero, wrap at the top
      acc_d = sum[`ACC_W+1] ? `ACC_RESET : sum[`ACC_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q <= `ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      upd.valid <= 1'b0;
      upd.value <= `CHARGE_RESET;
    end else begin
      upd.valid <= load_en | sample_valid;
      upd.value <= acc_d[`ACC_W-1:`ACC_FRAC];
    end
  end
endmodule : charge_integrator

// ### hdl/capacity_threshold_flags.sv
/*
  low-charge warning logic: integrates sense current and raises initial and final flags.
  assumes synchronous inputs, thresholds held stable by the host, one clock domain.
*/
`timescale 1ns/10ps
`include "capacity_threshold_flags_consts.svh"
module capacity_threshold_flags (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic signed [`SENSE_W-1:0] sense_sample,
  input  wire logic                       sample_valid,
  input  wire logic                       load_en,
  input  wire logic [`CAP_W-1:0]          load_value,
  input  wire logic [`LEVEL_W-1:0]        initial_flag_set_level,
  input  wire logic [`LEVEL_W-1:0]        final_flag_set_level,
  input  wire logic [`LEVEL_W-1:0]        final_flag_clear_level,
  output logic [`CAP_W-1:0]               remaining_charge_value,
  output logic [`FLAG_W-1:0]              flag_word,
  output logic                            low_battery_pin,
  output logic                            flags_updated
);
  charge_update_if upd ();

  capacity_threshold_flags_pkg::eval_state_e state_q;
  capacity_threshold_flags_pkg::charge_t     charge_q;
  logic                                      pending_q;
  logic                                      initial_low_charge_flag_q;
  logic                                      final_low_charge_flag_q;

  logic                                      capture_now;
  logic                                      compare_now;
  logic                                      publish_now;
  logic                                      busy_arrival;

  logic                                      final_enabled;
  logic                                      initial_below;
  logic                                      initial_above;
  logic                                      final_below;
  logic                                      final_above;

  wire  [`FLAG_W-1:0]                        flag_bits;

  charge_integrator u_integrator (
    .clock        (clock),
    .srst         (srst),
    .sense_sample (sense_sample),
    .sample_valid (sample_valid),
    .load_en      (load_en),
    .load_value   (load_value),
    .upd          (upd.source)
  );

  function automatic logic state_is(
    input capacity_threshold_flags_pkg::eval_state_e s,
    input capacity_threshold_flags_pkg::eval_state_e want
  );
    state_is = (s == want);
  endfunction : state_is

  function automatic logic [`CAP_W-1:0] widen(
    input logic [`LEVEL_W-1:0] l
  );
    widen = {{(`CAP_W-`LEVEL_W){1'b0}}, l};
  endfunction : widen

  function automatic logic below(
    input logic [`CAP_W-1:0]   c,
    input logic [`LEVEL_W-1:0] l
  );
    below = c < widen(l);
  endfunction : below

  function automatic logic above(
    input logic [`CAP_W-1:0]   c,
    input logic [`LEVEL_W-1:0] l
  );
    above = c > widen(l);
  endfunction : above

  // a value arriving mid-evaluation is held back, not lost
  assign busy_arrival = upd.valid && !state_is(state_q, capacity_threshold_flags_pkg::st_idle);
  assign capture_now  = state_is(state_q, capacity_threshold_flags_pkg::st_idle) && (upd.valid || pending_q);
  assign compare_now  = state_is(state_q, capacity_threshold_flags_pkg::st_compare);
  assign publish_now  = state_is(state_q, capacity_threshold_flags_pkg::st_publish);

  // comparisons on the captured charge; equal leaves a flag as it is
  assign final_enabled = (final_flag_set_level != `LEVEL_DISABLED);
  assign initial_below = below(charge_q, initial_flag_set_level);
  assign initial_above = above(charge_q, initial_flag_set_level);
  assign final_below   = below(charge_q, final_flag_set_level);
  assign final_above   = above(charge_q, final_flag_clear_level);

  // flag word image: the two warnings at their positions, spare bits zero
  for (genvar b = 0; b < `FLAG_W; b++) begin : g_flag_bits
    if (b == `FLAG_BIT_INITIAL) begin : g_initial
      assign flag_bits[b] = initial_low_charge_flag_q;
    end else if (b == `FLAG_BIT_FINAL) begin : g_final
      assign flag_bits[b] = final_low_charge_flag_q;
    end else begin : g_spare
      assign flag_bits[b] = 1'b0;
    end
  end

  // capture, compare, publish sequence per new charge value
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= capacity_threshold_flags_pkg::st_idle;
    end else begin
      unique case (state_q)
        capacity_threshold_flags_pkg::st_idle: begin
          if (capture_now) begin
            state_q <= capacity_threshold_flags_pkg::st_compare;
          end
        end
        capacity_threshold_flags_pkg::st_compare: begin
          state_q <= capacity_threshold_flags_pkg::st_publish;
        end
        capacity_threshold_flags_pkg::st_publish: begin
          state_q <= capacity_threshold_flags_pkg::st_idle;
        end
        default: begin
          state_q <= capacity_threshold_flags_pkg::st_idle;
        end
      endcase
    end
  end

  // remembers that the accumulator moved while an evaluation was running
  always_ff @(posedge clock) begin
    if (srst) begin
      pending_q <= 1'b0;
    end else if (busy_arrival) begin
      pending_q <= 1'b1;
    end else if (capture_now) begin
      pending_q <= 1'b0;
    end
  end

  // the integrator output always carries the newest charge
  always_ff @(posedge clock) begin
    if (srst) begin
      charge_q <= `CHARGE_RESET;
    end else if (capture_now) begin
      charge_q <= upd.value;
    end
  end

  // initial warning: one level both sets and clears
  always_ff @(posedge clock) begin
    if (srst) begin
      initial_low_charge_flag_q <= 1'b0;
    end else if (compare_now) begin
      if (initial_below) begin
        initial_low_charge_flag_q <= 1'b1;
      end else if (initial_above) begin
        initial_low_charge_flag_q <= 1'b0;
      end
    end
  end

  // final warning: set beats clear when both hold
  always_ff @(posedge clock) begin
    if (srst) begin
      final_low_charge_flag_q <= 1'b0;
    end else if (compare_now) begin
      if (final_enabled && final_below) begin
        final_low_charge_flag_q <= 1'b1;
      end else if (final_low_charge_flag_q && final_above) begin
        final_low_charge_flag_q <= 1'b0;
      end
    end
  end

  // outputs move together, one cycle after the compare
  always_ff @(posedge clock) begin
    if (srst) begin
      remaining_charge_value <= `CHARGE_RESET;
    end else if (publish_now) begin
      remaining_charge_value <= charge_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      flag_word <= `FLAGS_RESET;
    end else if (publish_now) begin
      flag_word <= flag_bits;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      low_battery_pin <= 1'b0;
    end else if (publish_now) begin
      low_battery_pin <= initial_low_charge_flag_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      flags_updated <= 1'b0;
    end else begin
      flags_updated <= publish_now;
    end
  end
endmodule : capacity_threshold_flags

// ### testbench/capacity_threshold_flags_sva.sv
/* port assertions for the low-charge flag block.
   assumes binding to capacity_threshold_flags from the bench. */
`timescale 1ns/10ps
`include "capacity_threshold_flags_consts.svh"
module capacity_threshold_flags_sva (
  input wire logic                clock,
  input wire logic                srst,
  input wire logic                load_en,
  input wire logic                sample_valid,
  input wire logic [`CAP_W-1:0]   load_value,
  input wire logic [`LEVEL_W-1:0] initial_flag_set_level,
  input wire logic [`LEVEL_W-1:0] final_flag_set_level,
  input wire logic [`LEVEL_W-1:0] final_flag_clear_level,
  input wire logic [`CAP_W-1:0]   remaining_charge_value,
  input wire logic [`FLAG_W-1:0]  flag_word,
  input wire logic                low_battery_pin,
  input wire logic                flags_updated
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire logic [`CAP_W-1:0] rc  = remaining_charge_value;
  wire logic              fi  = flag_word[`FLAG_BIT_INITIAL];
  wire logic              fl  = flag_word[`FLAG_BIT_FINAL];
  wire logic              arm = rc < final_flag_set_level && final_flag_set_level != `LEVEL_DISABLED;
  sequence s_quiet; (!load_en && !sample_valid)[*5]; endsequence
  sequence s_load; load_en ##1 (!load_en && !sample_valid)[*4]; endsequence
  property p_pin; low_battery_pin == fi; endproperty
  a_pin: assert property (p_pin) else $error("pin differs from initial flag");
  property p_iset; flags_updated && rc < initial_flag_set_level |-> fi; endproperty
  a_iset: assert property (p_iset) else $error("initial flag not set");
  property p_iclr; flags_updated && rc > initial_flag_set_level |-> !fi; endproperty
  a_iclr: assert property (p_iclr) else $error("initial flag not cleared");
  property p_fset; flags_updated && arm |-> fl; endproperty
  a_fset: assert property (p_fset) else $error("final flag not set");
  property p_fdis; flags_updated && final_flag_set_level == `LEVEL_DISABLED && !$past(fl) |-> !fl; endproperty
  a_fdis: assert property (p_fdis) else $error("disabled final flag was set");
  property p_fclr; flags_updated && !arm && !($past(fl) && rc <= final_flag_clear_level) |-> !fl; endproperty
  a_fclr: assert property (p_fclr) else $error("final flag not cleared");
  property p_word; (flag_word & ~16'h0006) == 16'h0000; endproperty
  a_word: assert property (p_word) else $error("spare flag bits set");
  property p_hold; !flags_updated && !$past(srst) |-> $stable(flag_word) && $stable(rc); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without update");
  property p_load; s_quiet ##1 s_load |-> rc == $past(load_value, 4) && flags_updated; endproperty
  a_load: assert property (p_load) else $error("loaded charge not shown");
endmodule : capacity_threshold_flags_sva

// ### testbench/flag_reader.sv
/* host side: keeps the flag word read after each update.
   assumes flags_updated marks a fresh word. */
`timescale 1ns/10ps
`include "capacity_threshold_flags_consts.svh"
module flag_reader (
  input  wire logic               clock,
  input  wire logic [`FLAG_W-1:0] flag_word,
  input  wire logic               flags_updated,
  output logic [`FLAG_W-1:0]      read_q
);
  always_ff @(posedge clock) begin
    if (flags_updated) begin
      read_q <= flag_word;
    end
  end
endmodule : flag_reader

// ### testbench/capacity_threshold_flags_bench.sv
/* self-checking bench for the low-charge flag block.
   assumes design, host model and checker compiled before it. */
`timescale 1ns/10ps
`include "capacity_threshold_flags_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module capacity_threshold_flags_bench;
  typedef struct packed { logic [15:0] v; logic [7:0] fs; logic [2:0] e; } row_s;
  logic                       clock = 1'b0, srst = 1'b1, sample_valid = 1'b0, load_en = 1'b0, pin, upd;
  logic signed [`SENSE_W-1:0] sense_sample = 16'h0000;
  logic [`CAP_W-1:0]          load_value = 16'h0000, rc;
  logic [`LEVEL_W-1:0]        il = 8'h96, fs = 8'h4b, fc = 8'h64;
  logic [`FLAG_W-1:0]         flag_word, read_q;
  int                         miscompares = 0, n_tests = 0, cycles = 0;
  row_s rows [9] = '{'{16'h00c8, 8'h4b, 3'h0}, '{16'h0078, 8'h4b, 3'h4}, '{16'h0032, 8'h4b, 3'h6},
    '{16'h005a, 8'h4b, 3'h6}, '{16'h006e, 8'h4b, 3'h4}, '{16'h005a, 8'h4b, 3'h4},
    '{16'h0096, 8'h4b, 3'h4}, '{16'h00a0, 8'h4b, 3'h0}, '{16'h0032, 8'hff, 3'h4}};
  capacity_threshold_flags DUT (.clock, .srst, .sense_sample, .sample_valid, .load_en, .load_value,
    .initial_flag_set_level(il), .final_flag_set_level(fs), .final_flag_clear_level(fc),
    .remaining_charge_value(rc), .flag_word, .low_battery_pin(pin), .flags_updated(upd));
  flag_reader host (.clock, .flag_word, .flags_updated(upd), .read_q);
  always #4 clock = ~clock;
  always @(posedge clock) begin
    if (++cycles == 1000) begin
      miscompares++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // one value serves as load value and sense sample
  task step(input logic l, input logic s, input logic [15:0] d);
    @(posedge clock);
    #1;
    load_en = l;
    sample_valid = s;
    load_value = d;
    sense_sample = d;
  endtask : step
  initial begin
    repeat (12) @(posedge clock);
    #1;
    `CHK({flag_word, pin, rc}, 33'h0)
    srst = 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      fs = rows[i].fs;
      step(1'b1, 1'b0, rows[i].v);
      step(1'b0, 1'b0, 16'h0000);
      repeat (8) begin
        @(posedge clock);
        #1;
        if (upd === 1'b1) break;
      end
      `CHK({flag_word, pin, rc}, {13'h0000, rows[i].e, rows[i].e[2], rows[i].v})
      // host copy lands one edge after the update pulse
      @(posedge clock);
      #1;
      `CHK(read_q, {13'h0000, rows[i].e})
      $display("row %0d done", i);
    end
    // back-to-back quarter-unit samples: +2 then -1
    step(1'b1, 1'b0, 16'h0064);
    repeat (8) step(1'b0, 1'b1, 16'h4000);
    repeat (4) step(1'b0, 1'b1, 16'hc000);
    step(1'b0, 1'b0, 16'h0000);
    repeat (10) @(posedge clock);
    #1;
    `CHK({flag_word, rc}, {16'h0004, 16'h0065})
    $display("integration test done");
    srst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK({flag_word, pin, rc}, 33'h0)
    srst = 1'b0;
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : capacity_threshold_flags_bench
bind capacity_threshold_flags capacity_threshold_flags_sva u_sva (.clock, .srst, .load_en, .sample_valid,
  .load_value, .initial_flag_set_level, .final_flag_set_level, .final_flag_clear_level,
  .remaining_charge_value, .flag_word, .low_battery_pin, .flags_updated);
